/* File: verilog/tdsd_pkg.sv */
/*
  Shared constants for the thread descriptor state decode block: register
  offsets, descriptor field positions, reset values and prefetch kinds.
  Assumes a 32-bit classic Wishbone register bus and byte-addressed state.
*/
package tdsd_pkg;

  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] ADDR_DESC_W1   = 8'h00;
  localparam logic [7:0] ADDR_DESC_W2   = 8'h04;
  localparam logic [7:0] ADDR_DESC_W3   = 8'h08;
  localparam logic [7:0] ADDR_GEN_BASE  = 8'h0c;
  localparam logic [7:0] ADDR_SURF_BASE = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;

  // Descriptor word one exception enables and their control word targets.
  localparam int DESC_ILLEGAL_OP_BIT = 13;
  localparam int DESC_FLOW_MASK_BIT  = 11;
  localparam int DESC_SW_EXC_BIT     = 7;
  localparam int CW1_ILLEGAL_OP_BIT  = 12;
  localparam int CW1_FLOW_MASK_BIT   = 11;
  localparam int CW1_SW_EXC_BIT      = 13;

  // Pointer and count fields of descriptor words two and three.
  localparam int          PTR_LSB        = 5;
  localparam int          SAMP_CNT_LSB   = 2;
  localparam int          SAMP_CNT_MSB   = 4;
  localparam int          BIND_CNT_MSB   = 4;
  localparam logic [2:0]  SAMP_CNT_MAX   = 3'h4;
  localparam logic [4:0]  SAMP_PER_UNIT  = 5'h04;
  localparam logic [4:0]  BIND_CNT_MAX   = 5'h1f;

  // Reset values.
  localparam logic [31:0] DESC_RESET     = 32'h0000_0000;
  localparam logic [31:0] BASE_RESET     = 32'h0000_0000;
  localparam logic [31:0] CW1_RESET      = 32'h0000_0000;

  // Status register fields.
  localparam int STAT_ARMED_BIT  = 0;
  localparam int STAT_BUSY_BIT   = 1;
  localparam int STAT_CHILD_BIT  = 2;
  localparam int STAT_ISSUED_LSB = 8;

  typedef enum logic [1:0] {
    TDSD_PF_NONE    = 2'h0,
    TDSD_PF_SAMPLER = 2'h1,
    TDSD_PF_BINDING = 2'h2
  } tdsd_pf_kind_e;

  // A 32-byte aligned offset taken from a descriptor word, added to a base.
  function automatic logic [31:0] state_addr(input logic [31:0] base,
                                             input logic [31:0] word);
    state_addr = base + {word[31:PTR_LSB], 5'h00};
  endfunction : state_addr

endpackage : tdsd_pkg

/* File: verilog/tdsd_field_decode.sv */
/*
  Combinational decode of descriptor words one to three into the control
  word image, the two state addresses and the two prefetch entry counts.
  Assumes the base addresses and words are stable registers of the top.
*/
`timescale 1ns/1ps
module tdsd_field_decode (
  input  wire logic [31:0] desc_w1,      // descriptor word one
  input  wire logic [31:0] desc_w2,      // descriptor word two
  input  wire logic [31:0] desc_w3,      // descriptor word three
  input  wire logic [31:0] gen_base,     // general state base
  input  wire logic [31:0] surf_base,    // surface state base
  output logic      [31:0] cw1_image,    // control word one image
  output logic      [31:0] samp_addr,    // sampler state table address
  output logic      [31:0] bind_addr,    // binding table address
  output logic      [4:0]  samp_entries, // sampler entries to prefetch
  output logic      [4:0]  bind_entries  // binding entries to prefetch
);

  logic [2:0] samp_units;

  always_comb begin
    cw1_image = tdsd_pkg::CW1_RESET;
    cw1_image[tdsd_pkg::CW1_ILLEGAL_OP_BIT] = desc_w1[tdsd_pkg::DESC_ILLEGAL_OP_BIT];
    cw1_image[tdsd_pkg::CW1_FLOW_MASK_BIT]  = desc_w1[tdsd_pkg::DESC_FLOW_MASK_BIT];
    cw1_image[tdsd_pkg::CW1_SW_EXC_BIT]     = desc_w1[tdsd_pkg::DESC_SW_EXC_BIT];
  end

  assign samp_addr = tdsd_pkg::state_addr(gen_base, desc_w2);
  assign bind_addr = tdsd_pkg::state_addr(surf_base, desc_w3);

  // sampler count decode.
  // Values beyond the documented range are clamped so a bad count never
  // prefetches more than sixteen sampler entries.
  always_comb begin
    samp_units = desc_w2[tdsd_pkg::SAMP_CNT_MSB:tdsd_pkg::SAMP_CNT_LSB];
    if (samp_units > tdsd_pkg::SAMP_CNT_MAX) begin
      samp_units = tdsd_pkg::SAMP_CNT_MAX;
    end
    samp_entries = 5'({2'h0, samp_units} * tdsd_pkg::SAMP_PER_UNIT);
  end

  assign bind_entries = desc_w3[tdsd_pkg::BIND_CNT_MSB:0];

endmodule : tdsd_field_decode

/* File: verilog/tdsd_prefetch_seq.sv */
/*
  Prefetch sequencer: walks the sampler entries, then the binding entries,
  issuing one request per entry with a valid and ready handshake.
  Assumes start is only given while idle and with a non-zero count.
*/
`timescale 1ns/1ps
module tdsd_prefetch_seq #(
  parameter logic [31:0] SAMP_ENTRY_BYTES = 32'h0000_0010, // sampler entry size
  parameter logic [31:0] BIND_ENTRY_BYTES = 32'h0000_0004  // binding entry size
) (
  input  wire logic                   clk,          // system clock
  input  wire logic                   rst,          // synchronous reset
  input  wire logic                   start,        // begin a prefetch pass
  input  wire logic [31:0]            samp_addr,    // sampler table address
  input  wire logic [31:0]            bind_addr,    // binding table address
  input  wire logic [4:0]             samp_entries, // sampler entry count
  input  wire logic [4:0]             bind_entries, // binding entry count
  output logic                        pf_valid,     // request is offered
  input  wire logic                   pf_ready,     // request is taken
  output logic [31:0]                 pf_addr,      // entry address
  output tdsd_pkg::tdsd_pf_kind_e     pf_kind,      // entry kind
  output logic                        busy          // pass in progress
);

  typedef enum logic [2:0] {
    TDSD_SQ_IDLE = 3'b001,
    TDSD_SQ_SAMP = 3'b010,
    TDSD_SQ_BIND = 3'b100
  } tdsd_sq_e;

  tdsd_sq_e    state_reg;
  logic [4:0]  idx_reg;
  logic [4:0]  bind_cnt_reg;
  logic [4:0]  samp_cnt_reg;
  logic [31:0] bind_base_reg;
  logic [31:0] addr_reg;
  logic        take;

  assign take     = pf_valid && pf_ready;
  assign pf_valid = state_reg != TDSD_SQ_IDLE;
  assign busy     = pf_valid;
  assign pf_addr  = addr_reg;
  assign pf_kind  = (state_reg == TDSD_SQ_SAMP) ? tdsd_pkg::TDSD_PF_SAMPLER :
                    (state_reg == TDSD_SQ_BIND) ? tdsd_pkg::TDSD_PF_BINDING :
                    tdsd_pkg::TDSD_PF_NONE;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg     <= TDSD_SQ_IDLE;
      idx_reg       <= 5'h00;
      addr_reg      <= tdsd_pkg::BASE_RESET;
      bind_cnt_reg  <= 5'h00;
      samp_cnt_reg  <= 5'h00;
      bind_base_reg <= tdsd_pkg::BASE_RESET;
    end else begin
      case (state_reg)
        TDSD_SQ_IDLE: begin
          if (start) begin
            idx_reg       <= 5'h00;
            samp_cnt_reg  <= samp_entries;
            bind_cnt_reg  <= bind_entries;
            bind_base_reg <= bind_addr;
            if (samp_entries != 5'h00) begin
              state_reg <= TDSD_SQ_SAMP;
              addr_reg  <= samp_addr;
            end else if (bind_entries != 5'h00) begin
              state_reg <= TDSD_SQ_BIND;
              addr_reg  <= bind_addr;
            end
          end
        end
        TDSD_SQ_SAMP: begin
          if (take) begin
            if (idx_reg + 5'h01 == samp_cnt_reg) begin
              idx_reg  <= 5'h00;
              addr_reg <= bind_base_reg;
              state_reg <= (bind_cnt_reg != 5'h00) ? TDSD_SQ_BIND : TDSD_SQ_IDLE;
            end else begin
              idx_reg  <= idx_reg + 5'h01;
              addr_reg <= addr_reg + SAMP_ENTRY_BYTES;
            end
          end
        end
        TDSD_SQ_BIND: begin
          if (take) begin
            if (idx_reg + 5'h01 == bind_cnt_reg) begin
              idx_reg   <= 5'h00;
              state_reg <= TDSD_SQ_IDLE;
            end else begin
              idx_reg  <= idx_reg + 5'h01;
              addr_reg <= addr_reg + BIND_ENTRY_BYTES;
            end
          end
        end
        default: begin
          state_reg <= TDSD_SQ_IDLE;
        end
      endcase
    end
  end

endmodule : tdsd_prefetch_seq

/* File: verilog/tdsd_top.sv */
/*
  Thread descriptor state decode: holds the later descriptor words behind a
  Wishbone slave, loads the execution unit control word on each dispatch,
  presents the state addresses of root threads and runs at most one state prefetch
  per media pipeline startup. Assumes the dispatcher and state cache run on
  CLK_SYS and hold their pulses for one cycle.
*/
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module tdsd_top #(
  parameter logic [31:0] SAMP_ENTRY_BYTES = 32'h0000_0010, // sampler entry size
  parameter logic [31:0] BIND_ENTRY_BYTES = 32'h0000_0004  // binding entry size
) (
  input  wire logic                   CLK_SYS,        // system clock, 200 MHz
  input  wire logic                   RST,            // synchronous reset
  input  wire logic                   WB_CYC_I,       // bus cycle
  input  wire logic                   WB_STB_I,       // bus strobe
  input  wire logic                   WB_WE_I,        // write enable
  input  wire logic [7:0]             WB_ADR_I,       // byte address
  input  wire logic [3:0]             WB_SEL_I,       // byte selects
  input  wire logic [31:0]            WB_DAT_I,       // write data
  output logic      [31:0]            WB_DAT_O,       // read data
  output logic                        WB_ACK_O,       // acknowledge
  input  wire logic                   PIPE_START,     // media pipeline startup pulse
  input  wire logic                   DISP_VALID,     // thread dispatch pulse
  input  wire logic                   DISP_CHILD,     // dispatched thread is a child
  output logic      [31:0]            EXEC_UNIT_CONTROL_WORD_ONE, // control word one
  output logic                        EXEC_UNIT_LOAD, // control word loaded pulse
  output logic      [31:0]            SAMP_STATE_ADDR, // sampler state table address
  output logic      [31:0]            BIND_TABLE_ADDR, // binding table address
  output logic                        PF_VALID,       // prefetch request valid
  input  wire logic                   PF_READY,       // prefetch request taken
  output logic      [31:0]            PF_ADDR,        // prefetch entry address
  output tdsd_pkg::tdsd_pf_kind_e     PF_KIND         // prefetch entry kind
);

  logic [31:0] desc_w1_reg;
  logic [31:0] desc_w2_reg;
  logic [31:0] desc_w3_reg;
  logic [31:0] gen_base_reg;
  logic [31:0] surf_base_reg;
  logic [31:0] cw1_reg;
  logic        load_reg;
  logic [31:0] samp_addr_reg;
  logic [31:0] bind_addr_reg;
  logic        armed_reg;
  logic        child_reg;
  logic [7:0]  issued_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  logic        bus_req;
  logic        bus_wr;
  logic [31:0] cw1_image;
  logic [31:0] samp_addr;
  logic [31:0] bind_addr;
  logic [4:0]  samp_entries;
  logic [4:0]  bind_entries;
  logic        root_disp;
  logic        seq_start;
  logic        seq_busy;

  // Bus slave: one wait state, ack drops in the cycle after it is given.
  assign bus_req = WB_CYC_I && WB_STB_I && !ack_reg;
  assign bus_wr  = bus_req && WB_WE_I;
  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdata_reg;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    merge_bytes = res;
  endfunction : merge_bytes

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (WB_ADR_I)
      tdsd_pkg::ADDR_DESC_W1:   rdata_next = desc_w1_reg;
      tdsd_pkg::ADDR_DESC_W2:   rdata_next = desc_w2_reg;
      tdsd_pkg::ADDR_DESC_W3:   rdata_next = desc_w3_reg;
      tdsd_pkg::ADDR_GEN_BASE:  rdata_next = gen_base_reg;
      tdsd_pkg::ADDR_SURF_BASE: rdata_next = surf_base_reg;
      tdsd_pkg::ADDR_STATUS: begin
        rdata_next[tdsd_pkg::STAT_ARMED_BIT] = armed_reg;
        rdata_next[tdsd_pkg::STAT_BUSY_BIT]  = seq_busy;
        rdata_next[tdsd_pkg::STAT_CHILD_BIT] = child_reg;
        rdata_next[tdsd_pkg::STAT_ISSUED_LSB +: 8] = issued_reg;
      end
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus_req && !WB_WE_I) begin
      rdata_reg <= rdata_next;
    end
  end

  // Writes land with the request cycle so they are visible when ack rises.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      desc_w1_reg   <= tdsd_pkg::DESC_RESET;
      desc_w2_reg   <= tdsd_pkg::DESC_RESET;
      desc_w3_reg   <= tdsd_pkg::DESC_RESET;
      gen_base_reg  <= tdsd_pkg::BASE_RESET;
      surf_base_reg <= tdsd_pkg::BASE_RESET;
    end else if (bus_wr) begin
      case (WB_ADR_I)
        tdsd_pkg::ADDR_DESC_W1:   desc_w1_reg   <= merge_bytes(desc_w1_reg, WB_DAT_I, WB_SEL_I);
        tdsd_pkg::ADDR_DESC_W2:   desc_w2_reg   <= merge_bytes(desc_w2_reg, WB_DAT_I, WB_SEL_I);
        tdsd_pkg::ADDR_DESC_W3:   desc_w3_reg   <= merge_bytes(desc_w3_reg, WB_DAT_I, WB_SEL_I);
        tdsd_pkg::ADDR_GEN_BASE:  gen_base_reg  <= merge_bytes(gen_base_reg, WB_DAT_I, WB_SEL_I);
        tdsd_pkg::ADDR_SURF_BASE: surf_base_reg <= merge_bytes(surf_base_reg, WB_DAT_I, WB_SEL_I);
        default: begin
        end
      endcase
    end
  end

  tdsd_field_decode u_decode (
    .desc_w1      (desc_w1_reg),
    .desc_w2      (desc_w2_reg),
    .desc_w3      (desc_w3_reg),
    .gen_base     (gen_base_reg),
    .surf_base    (surf_base_reg),
    .cw1_image    (cw1_image),
    .samp_addr    (samp_addr),
    .bind_addr    (bind_addr),
    .samp_entries (samp_entries),
    .bind_entries (bind_entries)
  );

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cw1_reg  <= tdsd_pkg::CW1_RESET;
      load_reg <= 1'b0;
    end else begin
      load_reg <= DISP_VALID;
      if (DISP_VALID) begin
        cw1_reg <= cw1_image;
      end
    end
  end

  assign EXEC_UNIT_CONTROL_WORD_ONE = cw1_reg;
  assign EXEC_UNIT_LOAD             = load_reg;

  assign root_disp = DISP_VALID && !DISP_CHILD;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      samp_addr_reg <= tdsd_pkg::BASE_RESET;
      bind_addr_reg <= tdsd_pkg::BASE_RESET;
      child_reg     <= 1'b0;
    end else if (DISP_VALID) begin
      child_reg <= DISP_CHILD;
      if (!DISP_CHILD) begin
        samp_addr_reg <= samp_addr;
        bind_addr_reg <= bind_addr;
      end
    end
  end

  assign SAMP_STATE_ADDR = samp_addr_reg;
  assign BIND_TABLE_ADDR = bind_addr_reg;

  // one pass per startup; a startup in the same cycle as the
  // consuming dispatch wins, so the next startup is never lost.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      armed_reg <= 1'b0;
    end else if (PIPE_START) begin
      armed_reg <= 1'b1;
    end else if (root_disp) begin
      armed_reg <= 1'b0;
    end
  end

  // start only for the first root thread after a startup, and only if it has counts.
  assign seq_start = root_disp && armed_reg && !seq_busy &&
                     (samp_entries != 5'h00 || bind_entries != 5'h00);

  // counts size the prefetch walk, and block its start when both are zero.
  tdsd_prefetch_seq #(
    .SAMP_ENTRY_BYTES (SAMP_ENTRY_BYTES),
    .BIND_ENTRY_BYTES (BIND_ENTRY_BYTES)
  ) u_seq (
    .clk          (CLK_SYS),
    .rst          (RST),
    .start        (seq_start),
    .samp_addr    (samp_addr),
    .bind_addr    (bind_addr),
    .samp_entries (samp_entries),
    .bind_entries (bind_entries),
    .pf_valid     (PF_VALID),
    .pf_ready     (PF_READY),
    .pf_addr      (PF_ADDR),
    .pf_kind      (PF_KIND),
    .busy         (seq_busy)
  );

  // Counts requests taken in the current pass; reset by each start.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      issued_reg <= 8'h00;
    end else if (seq_start) begin
      issued_reg <= 8'h00;
    end else if (PF_VALID && PF_READY) begin
      issued_reg <= issued_reg + 8'h01;
    end
  end

  logic [5:0] bind_taken_reg;

  always_ff @(posedge CLK_SYS) begin
    if (RST || seq_start) begin
      bind_taken_reg <= 6'h00;
    end else if (PF_VALID && PF_READY && PF_KIND == tdsd_pkg::TDSD_PF_BINDING) begin
      bind_taken_reg <= bind_taken_reg + 6'h01;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  illegal_op_copy_a: assert property (
    DISP_VALID |=> cw1_reg[12] == $past(desc_w1_reg[13]) && load_reg)
    else $error("illegal opcode enable not copied");

  flow_mask_copy_a: assert property (
    DISP_VALID |=> EXEC_UNIT_CONTROL_WORD_ONE[11] == $past(desc_w1_reg[11]))
    else $error("flow mask depth enable not copied");

  sw_exc_copy_a: assert property (
    DISP_VALID |=> EXEC_UNIT_CONTROL_WORD_ONE[13] == $past(desc_w1_reg[7]))
    else $error("software exception enable not copied");

  samp_addr_form_a: assert property (
    root_disp |=> SAMP_STATE_ADDR ==
      $past(gen_base_reg) + {$past(desc_w2_reg[31:5]), 5'h00})
    else $error("sampler state address wrong");

  bind_addr_form_a: assert property (
    root_disp |=> BIND_TABLE_ADDR ==
      $past(surf_base_reg) + {$past(desc_w3_reg[31:5]), 5'h00})
    else $error("binding table address wrong");

  child_ignored_a: assert property (
    DISP_VALID && DISP_CHILD |=> $stable(SAMP_STATE_ADDR) && $stable(BIND_TABLE_ADDR)
      && !$rose(PF_VALID))
    else $error("child thread changed state pointers");

  samp_prefetch_a: assert property (
    seq_start && samp_entries != 5'h00 |=> PF_VALID && PF_KIND == tdsd_pkg::TDSD_PF_SAMPLER
      && PF_ADDR == $past(samp_addr))
    else $error("sampler prefetch not started");

  bind_prefetch_a: assert property (
    seq_start && samp_entries == 5'h00 |=> PF_VALID && PF_KIND == tdsd_pkg::TDSD_PF_BINDING)
    else $error("binding prefetch not started");

  samp_limit_a: assert property (
    PF_VALID && PF_KIND == tdsd_pkg::TDSD_PF_SAMPLER |-> issued_reg < 8'h10)
    else $error("more than sixteen sampler entries");

  bind_limit_a: assert property (
    bind_taken_reg <= 6'h1f)
    else $error("more than 31 binding entries");

  once_per_start_a: assert property (
    root_disp && armed_reg && !PIPE_START |=> !armed_reg ##1 (!seq_start || $past(PIPE_START)))
    else $error("second prefetch in one startup");

  zero_counts_idle_a: assert property (
    root_disp && !seq_busy && samp_entries == 5'h00 && bind_entries == 5'h00
      |=> !PF_VALID)
    else $error("prefetch with both counts zero");

  // The walk must hold each offer until the cache takes it, or entries are lost.
  pf_offer_hold_a: assert property (
    PF_VALID && !PF_READY |=> PF_VALID && $stable(PF_ADDR) && $stable(PF_KIND))
    else $error("prefetch offer changed before it was taken");

  samp_step_a: assert property (
    PF_VALID && PF_READY && PF_KIND == tdsd_pkg::TDSD_PF_SAMPLER |=>
      PF_KIND != tdsd_pkg::TDSD_PF_SAMPLER ||
      PF_ADDR == $past(PF_ADDR) + SAMP_ENTRY_BYTES)
    else $error("sampler entry address did not advance");

  bind_step_a: assert property (
    PF_VALID && PF_READY && PF_KIND == tdsd_pkg::TDSD_PF_BINDING |=>
      PF_KIND != tdsd_pkg::TDSD_PF_BINDING ||
      PF_ADDR == $past(PF_ADDR) + BIND_ENTRY_BYTES)
    else $error("binding entry address did not advance");

  load_pulse_a: assert property (
    EXEC_UNIT_LOAD == $past(DISP_VALID))
    else $error("control word load pulse misplaced");

  child_flag_a: assert property (
    DISP_VALID |=> child_reg == $past(DISP_CHILD))
    else $error("child flag not recorded");

  // A second cycle of ack would let the master finish a request twice.
  bus_ack_pulse_a: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("bus acknowledge longer than one cycle");

endmodule : tdsd_top

/* File: test/tdsd_cache_model.sv */
/*
  State cache model: takes prefetch requests and records them in order.
  Assumes a valid and ready handshake on clk; slow halves the take rate.
*/
`timescale 1ns/1ps
module tdsd_cache_model (
  input  wire logic        clk,      // system clock
  input  wire logic        rst,      // synchronous reset
  input  wire logic        slow,     // answer every other cycle
  input  wire logic        pf_valid, // request offered
  input  wire logic [31:0] pf_addr,  // entry address
  input  tdsd_pkg::tdsd_pf_kind_e pf_kind, // entry kind
  output logic             pf_ready  // request taken
);
  logic [31:0]             q_addr [$];
  tdsd_pkg::tdsd_pf_kind_e q_kind [$];
  logic                    toggle_reg;

  assign pf_ready = !slow || toggle_reg;

  always @(posedge clk) begin
    toggle_reg <= rst ? 1'b0 : !toggle_reg;
    if (!rst && pf_valid && pf_ready) begin
      q_addr.push_back(pf_addr);
      q_kind.push_back(pf_kind);
    end
  end
endmodule : tdsd_cache_model

/* File: test/tb.sv */
/*
  Self-checking bench for the descriptor decode block.
  Assumes the cache model answers prefetch requests at the far side.
*/
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rq, cw, saddr, baddr, pfa;
  logic        ack, load, pfv, pfr;
  logic        start = 1'b0;
  logic        dv = 1'b0;
  logic        child = 1'b0;
  logic        slow = 1'b0;
  tdsd_pkg::tdsd_pf_kind_e pfk;
  int          fails = 0;
  int          n_compared = 0;
  int          cycles = 0;

  tdsd_top dut (.CLK_SYS(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .PIPE_START(start), .DISP_VALID(dv), .DISP_CHILD(child),
    .EXEC_UNIT_CONTROL_WORD_ONE(cw), .EXEC_UNIT_LOAD(load), .SAMP_STATE_ADDR(saddr),
    .BIND_TABLE_ADDR(baddr), .PF_VALID(pfv), .PF_READY(pfr), .PF_ADDR(pfa), .PF_KIND(pfk));
  tdsd_cache_model m (.clk(clk), .rst(rst), .slow(slow), .pf_valid(pfv), .pf_addr(pfa),
    .pf_kind(pfk), .pf_ready(pfr));

  initial begin
    forever #2.5 clk = !clk;
  end

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic check32(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : check32

  // Read data is taken at the rising edge that samples ack high, and released there.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rq = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic disp(input logic c);
    @(posedge clk);
    dv <= 1'b1;
    child <= c;
    @(posedge clk);
    dv <= 1'b0;
    @(negedge clk);
    check32(32'h1, {31'h0, load});
  endtask : disp

  task automatic t_ctrl();
    logic [31:0] din [4] = '{32'h2000, 32'h0800, 32'h0080, 32'h2880};
    logic [31:0] exp [4] = '{32'h1000, 32'h0800, 32'h2000, 32'h3800};
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, tdsd_pkg::ADDR_DESC_W1, din[i]);
      disp(1'b1);
      check32(exp[i], cw);
    end
    wb(1'b0, 8'h20, 32'h0);
    check32(32'h0, rq);
    $display("Control word test done");
  endtask : t_ctrl

  task automatic t_addr();
    wb(1'b1, tdsd_pkg::ADDR_GEN_BASE, 32'h1000_0000);
    wb(1'b1, tdsd_pkg::ADDR_SURF_BASE, 32'h2000_0000);
    wb(1'b1, tdsd_pkg::ADDR_DESC_W2, 32'h0001_2340);
    wb(1'b1, tdsd_pkg::ADDR_DESC_W3, 32'h0004_5660);
    disp(1'b0);
    check32(32'h1001_2340, saddr);
    check32(32'h2004_5660, baddr);
    wb(1'b1, tdsd_pkg::ADDR_DESC_W2, 32'h0000_0fe0);
    disp(1'b1);
    check32(32'h1001_2340, saddr);
    wb(1'b0, tdsd_pkg::ADDR_STATUS, 32'h0);
    check32(32'h4, {29'h0, rq[2:0]});
    $display("Address test done");
  endtask : t_addr

  // A child dispatch and a second root dispatch come between arm and the end check.
  task automatic t_pf(input logic [2:0] sc, input logic [4:0] bc, input logic s);
    int n = 4 * sc + bc;
    int k = 0;
    m.q_addr.delete();
    m.q_kind.delete();
    slow <= s;
    wb(1'b1, tdsd_pkg::ADDR_DESC_W2, {27'h100, sc, 2'h0});
    wb(1'b1, tdsd_pkg::ADDR_DESC_W3, {27'h180, bc});
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    disp(1'b1);
    check32(32'h0, m.q_addr.size());
    disp(1'b0);
    while (m.q_addr.size() < n && k < 400) begin
      @(posedge clk);
      k++;
    end
    disp(1'b0);
    repeat (4) @(posedge clk);
    check32(n, m.q_addr.size());
    for (int i = 0; i < n && i < m.q_addr.size(); i++) begin
      if (i < 4 * sc) begin
        check32(32'h1000_2000 + 16 * i, m.q_addr[i]);
        check32(32'h1, {30'h0, m.q_kind[i]});
      end else begin
        check32(32'h2000_3000 + 4 * (i - 4 * sc), m.q_addr[i]);
        check32(32'h2, {30'h0, m.q_kind[i]});
      end
    end
    wb(1'b0, tdsd_pkg::ADDR_STATUS, 32'h0);
    check32(32'h0, {29'h0, rq[2:0]});
    if (n > 0) begin
      check32(n, {24'h0, rq[15:8]});
    end
    $display("Prefetch test done, %0d entries", n);
  endtask : t_pf

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_ctrl();
    t_addr();
    t_pf(3'h1, 5'h00, 1'b0);
    t_pf(3'h4, 5'h1f, 1'b1);
    t_pf(3'h0, 5'h05, 1'b0);
    t_pf(3'h0, 5'h00, 1'b0);
    t_pf(3'h2, 5'h01, 1'b1);
    t_pf(3'h3, 5'h00, 1'b0);
    give_verdict();
  end
endmodule : tb
